// File: core/link_rx_pkg.sv
// constants, types and the contract of the block-mode receiver and its low-power control
// assumes one 50 MHz clock and a symbol decoder on that same clock ahead of it
// Contract
// [R1] receiver accepts block frames, never transmits them
// [R2] block frame: normal frame, unbounded byte count
// [R3] software sets block bit before frame arrives
// [R4] full buffer spills over, success flag raised
// [R5] software empties each filled buffer in time
// [R6] running crc spans every buffer switch
// [R7] good end: success, block bit cleared, interrupt
// [R8] overflow: reset pointers, clear bit, wait
// [R9] other block errors act like overflow
// [R10] block bit clear: block frames ignored
// [R11] stop entered on stop, or wait with select
// [R12] stop: bus rising edge wakes, raises nmi
// [R13] waking frame may be lost while stabilising
// [R14] stop mid-frame: first edge wakes at once
// [R15] stop and wait put transmitter asleep
// [R16] software finishes transmissions before sleeping
// [R17] wait entered on wait without select
// [R18] wait: good frame captured, wakes by interrupt
// [R19] software drives power sense per mode
// [R20] status access clears flag unless more waiting
// [R21] status write releases the oldest buffer
// [R22] after reset filling restarts at buffer zero
package link_rx_pkg;
    // symbol kinds delivered by the decoder
    localparam logic [1:0] K_SOF = 2'h0;
    localparam logic [1:0] K_DATA = 2'h1;
    localparam logic [1:0] K_EOD = 2'h2;
    localparam logic [1:0] K_ERR = 2'h3;
    localparam int KIND_W = 2;
    localparam int BYTE_W = 8;
    localparam int ENTRY_W = BYTE_W + KIND_W + 1;
    localparam int FIFO_DEPTH = 16;
    localparam int BUF_DEPTH = 12;
    // crc over the frame, checked by its residue
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h1d;
    localparam logic [7:0] CRC_RESIDUE = 8'hc4;
    // clock restart time after a stop wake-up
    localparam int CLK_MHZ = 50;
    localparam int STAB_TIME_US = 100;
    localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
    localparam logic BLK_BIT_RST = 1'b0;
    localparam logic SENSE_RST = 1'b0;
    typedef enum logic [1:0] {F_IDLE, F_NORM, F_BLK} frame_state_type;
    typedef enum logic [1:0] {P_RUN, P_WAIT, P_STOP, P_STAB} power_mode_type;
endpackage : link_rx_pkg

// File: core/sync_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes both sides on the same clock
`timescale 1ns/1ps
module sync_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic mclk, // clock
    input wire logic arst_n, // async reset, low
    input wire logic ce, // clock enable
    input wire logic in_valid, // write request
    output logic in_ready, // room left
    input wire logic [W-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // drain accepts
    output logic [W-1:0] out_data // oldest word
);
    localparam int AW = $clog2(D);
    if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad_cfg
        $error("fifo depth must be a power of two");
    end
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    // honest full and empty from the fill count
    assign in_ready = (cnt_reg != (AW+1)'(D));
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid & in_ready & ce;
    assign pop = out_valid & out_ready & ce;
    assign out_data = mem[rd_reg];
    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    // pointers and count
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    property p_no_push_full;
        @(posedge mclk) disable iff (!arst_n) (cnt_reg == (AW+1)'(D)) |=> cnt_reg <= (AW+1)'(D);
    endproperty
    a_no_push_full: assert property (p_no_push_full) else $error("fifo count above depth");
endmodule : sync_fifo

// File: core/crc8_unit.sv
// running crc register updated one byte at a time
// assumes clear and update come from logic on the same clock
`timescale 1ns/1ps
module crc8_unit
    import link_rx_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic arst_n, // async reset, low
    input wire logic ce, // clock enable
    input wire logic clr, // restart at frame start
    input wire logic en, // absorb one byte
    input wire logic [7:0] din, // byte in
    output logic [7:0] crc // running value
);
    // msb-first byte step of the polynomial
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step
    // running crc across the whole frame
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            crc <= CRC_INIT;
        end else if (ce) begin
            if (clr) crc <= CRC_INIT;
            else if (en) crc <= crc_step(crc, din); // R6
        end
    end
endmodule : crc8_unit

// File: core/message_link_controller.sv
// receive buffers, block-mode spill-over and stop/wait control of the link controller
// assumes a symbol decoder on mclk, a raw receive pin and cpu sleep strobes on mclk
`timescale 1ns/1ps
module message_link_controller
    import link_rx_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH,
    parameter int STAB_CYC = STAB_CYCLES
) (
    input wire logic mclk, // 50 MHz clock
    input wire logic arst_n, // async reset, low
    input wire logic ce, // clock enable
    input wire logic sym_valid, // decoded symbol valid
    output logic sym_ready, // symbol fifo has room
    input wire logic [1:0] sym_kind, // sof, data, eod or error
    input wire logic sym_block, // sof announces a block frame
    input wire logic [7:0] sym_byte, // data byte
    input wire logic rxp, // raw receive pin, high active
    input wire logic cpu_stop, // stop instruction pulse
    input wire logic cpu_wait, // wait instruction pulse
    input wire logic blk_mode_set, // software sets the block bit
    input wire logic wait_stop_select_bit, // wait acts as stop
    input wire logic irq_enable_bit, // receive interrupt enable
    input wire logic rx_status_access, // status read or write pulse
    input wire logic [$clog2(DEPTH)-1:0] rd_index, // byte index in oldest buffer
    input wire logic sense_wr, // power sense write strobe
    input wire logic sense_val, // power sense value
    output logic [7:0] rd_data, // buffer byte
    output logic [$clog2(DEPTH+1)-1:0] rx_count, // bytes in oldest buffer
    output logic rx_block_mode_bit, // block reception armed
    output logic rx_success_flag, // message waiting
    output logic rx_overflow, // block overflow pulse
    output logic rx_irq, // receive interrupt request
    output logic wake_nmi, // wake pulse, non-maskable
    output logic tx_sleep, // transmitter analog asleep
    output logic power_sense_out // power sense port
);
    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam int SW = $clog2(STAB_CYC+1);
    if (DEPTH < 2 || STAB_CYC < 16) begin : g_bad_cfg
        $error("buffer depth or restart time too small");
    end

    logic f_valid;
    logic f_pop;
    logic [ENTRY_W-1:0] f_data;
    logic f_blk;
    logic [1:0] f_kind;
    logic [7:0] f_byte;
    logic [7:0] crc;
    frame_state_type st_reg;
    power_mode_type pmode_reg;
    logic [7:0] mem [2][DEPTH];
    logic [CW-1:0] cnt_reg [2];
    logic [CW-1:0] wptr_reg;
    logic [1:0] full_reg;
    logic wbuf_reg;
    logic head_reg;
    logic [SW-1:0] stab_reg;
    logic rxp_s1_reg;
    logic rxp_s2_reg;
    logic rxp_s3_reg;
    logic rx_rise;
    logic drain_ok;
    logic discard;
    logic pop_ok;
    logic is_sof;
    logic is_data;
    logic is_eod;
    logic is_err;
    logic buf_end;
    logic crc_ok;
    logic other_full;
    logic blk_spill;
    logic blk_over;
    logic blk_abort;
    logic blk_done;
    logic norm_done;
    logic fill_evt;
    logic release_evt;
    logic wr_en;
    logic wr_buf;
    logic [IW-1:0] wr_idx;

    // symbol fifo; drain stalls while the clocks are stopped
    sync_fifo #(.W(ENTRY_W), .D(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(sym_valid),
        .in_ready(sym_ready),
        .in_data({sym_block, sym_kind, sym_byte}),
        .out_valid(f_valid),
        .out_ready(drain_ok),
        .out_data(f_data)
    );
    assign {f_blk, f_kind, f_byte} = f_data;

    // running crc, cleared only at frame start so buffer switches keep it
    crc8_unit u_crc (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .clr(pop_ok & is_sof),
        .en(pop_ok & is_data & (st_reg != F_IDLE)), // R6
        .din(f_byte),
        .crc(crc)
    );

    // receive pin synchroniser and passive-to-active edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rxp_s1_reg <= 1'b0;
            rxp_s2_reg <= 1'b0;
            rxp_s3_reg <= 1'b0;
        end else if (ce) begin
            rxp_s1_reg <= rxp;
            rxp_s2_reg <= rxp_s1_reg;
            rxp_s3_reg <= rxp_s2_reg;
        end
    end
    assign rx_rise = rxp_s2_reg & ~rxp_s3_reg;

    // symbol decode and frame events
    assign drain_ok = (pmode_reg != P_STOP);
    assign discard = (pmode_reg == P_STAB); // R13
    assign f_pop = f_valid & drain_ok & ce;
    assign pop_ok = f_pop & ~discard;
    assign is_sof = (f_kind == K_SOF);
    assign is_data = (f_kind == K_DATA);
    assign is_eod = (f_kind == K_EOD);
    assign is_err = (f_kind == K_ERR);
    assign buf_end = (wptr_reg == CW'(DEPTH));
    assign crc_ok = (crc == CRC_RESIDUE);
    assign other_full = full_reg[~wbuf_reg];
    assign blk_spill = pop_ok & is_data & (st_reg == F_BLK) & buf_end; // R4
    assign blk_over = blk_spill & other_full; // R8
    assign blk_abort = blk_over | (pop_ok & (st_reg == F_BLK)
                       & (is_err | is_sof | (is_eod & ~crc_ok))); // R9
    assign blk_done = pop_ok & (st_reg == F_BLK) & is_eod & crc_ok; // R7
    assign norm_done = pop_ok & (st_reg == F_NORM) & is_eod & crc_ok
                       & (wptr_reg != '0);
    assign fill_evt = norm_done | blk_done | (blk_spill & ~other_full); // R4
    assign release_evt = rx_status_access & ce; // R21

    // buffer write port; a spilled byte lands at the bottom of the other buffer
    assign wr_en = pop_ok & is_data & ~blk_over
                   & (((st_reg == F_NORM) & ~buf_end) | (st_reg == F_BLK)); // R2
    assign wr_buf = blk_spill ? ~wbuf_reg : wbuf_reg;
    assign wr_idx = blk_spill ? '0 : wptr_reg[IW-1:0];

    // receive buffer storage and read port
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_buf][wr_idx] <= f_byte;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= mem[head_reg][rd_index];
        end
    end

    // frame state; block frames enter only with the block bit armed
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= F_IDLE;
        end else if (ce) begin
            if (discard || pmode_reg == P_STOP) begin
                st_reg <= F_IDLE; // R14
            end else if (pop_ok) begin
                unique case (f_kind)
                    K_SOF: begin
                        if (st_reg == F_BLK) st_reg <= F_IDLE; // R9
                        else if (f_blk) st_reg <= (rx_block_mode_bit && !full_reg[wbuf_reg]) // R1
                                                  ? F_BLK : F_IDLE; // R10
                        else st_reg <= full_reg[wbuf_reg] ? F_IDLE : F_NORM;
                    end
                    K_DATA: begin
                        if (blk_abort || (st_reg == F_NORM && buf_end)) st_reg <= F_IDLE;
                    end
                    K_EOD, K_ERR: st_reg <= F_IDLE;
                endcase
            end
        end
    end

    // write pointer within the filling buffer
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_reg <= '0;
        end else if (ce) begin
            if (blk_abort || discard || (pop_ok && is_sof)) wptr_reg <= '0; // R8
            else if (blk_spill) wptr_reg <= CW'(1); // R4
            else if (wr_en) wptr_reg <= wptr_reg + 1'b1;
        end
    end

    // buffer ownership: filled in turn, released oldest first
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            full_reg <= 2'h0;
            wbuf_reg <= 1'b0;
            head_reg <= 1'b0;
            cnt_reg[0] <= '0;
            cnt_reg[1] <= '0;
        end else if (ce) begin
            if (blk_abort) begin
                full_reg <= 2'h0; // R8
                wbuf_reg <= 1'b0; // R22
                head_reg <= 1'b0; // R22
            end else begin
                if (release_evt && full_reg[head_reg]) begin
                    full_reg[head_reg] <= 1'b0; // R20
                    head_reg <= ~head_reg;
                end
                if (fill_evt) begin
                    full_reg[wbuf_reg] <= 1'b1;
                    cnt_reg[wbuf_reg] <= wptr_reg;
                    wbuf_reg <= ~wbuf_reg;
                end
            end
        end
    end
    assign rx_success_flag = |full_reg; // R20
    assign rx_count = cnt_reg[head_reg];
    assign rx_irq = rx_success_flag & irq_enable_bit; // R18

    // block mode bit; software arming wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_block_mode_bit <= BLK_BIT_RST;
        end else if (ce) begin
            if (blk_mode_set) rx_block_mode_bit <= 1'b1;
            else if (blk_done || blk_abort) rx_block_mode_bit <= 1'b0; // R7
        end
    end

    // overflow pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_overflow <= 1'b0;
        end else if (ce) begin
            rx_overflow <= blk_over; // R8
        end
    end

    // power mode: run, wait, stop and clock restart
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pmode_reg <= P_RUN;
        end else if (ce) begin
            unique case (pmode_reg)
                P_RUN: begin
                    if (cpu_stop || (cpu_wait && wait_stop_select_bit)) pmode_reg <= P_STOP; // R11
                    else if (cpu_wait) pmode_reg <= P_WAIT; // R17
                end
                P_WAIT: if (fill_evt && irq_enable_bit) pmode_reg <= P_RUN; // R18
                P_STOP: if (rx_rise) pmode_reg <= P_STAB; // R12
                P_STAB: if (stab_reg == SW'(STAB_CYC - 1)) pmode_reg <= P_RUN; // R14
            endcase
        end
    end

    // restart counter and wake pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stab_reg <= '0;
            wake_nmi <= 1'b0;
        end else if (ce) begin
            stab_reg <= (pmode_reg == P_STAB) ? stab_reg + 1'b1 : '0;
            wake_nmi <= (pmode_reg == P_STOP) & rx_rise; // R12
        end
    end
    assign tx_sleep = (pmode_reg != P_RUN); // R15

    // power sense port written by software
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            power_sense_out <= SENSE_RST;
        end else if (ce && sense_wr) begin
            power_sense_out <= sense_val;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_stop_entry;
        (ce && pmode_reg == P_RUN && cpu_stop) |=> tx_sleep && pmode_reg == P_STOP;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop not entered"); // R11
    property p_wait_entry;
        (ce && pmode_reg == P_RUN && cpu_wait && !cpu_stop && !wait_stop_select_bit)
            |=> pmode_reg == P_WAIT && tx_sleep;
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("wait not entered"); // R17
    property p_wake;
        (ce && pmode_reg == P_STOP && rx_rise) |=> wake_nmi && pmode_reg == P_STAB;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on bus edge"); // R12
    property p_restart_hold;
        (ce && wake_nmi) |-> (pmode_reg == P_STAB && !norm_done)[*8];
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart too short"); // R13
    property p_blk_done;
        (ce && blk_done && !blk_mode_set) |=> !rx_block_mode_bit && rx_success_flag;
    endproperty
    a_blk_done: assert property (p_blk_done) else $error("block end mishandled"); // R7
    property p_overflow;
        (ce && blk_over) |=> rx_overflow && !rx_success_flag && wbuf_reg == 1'b0
            && wptr_reg == '0;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not reset"); // R8
    property p_spill;
        (ce && blk_spill && !other_full) |=> rx_success_flag && wptr_reg == CW'(1);
    endproperty
    a_spill: assert property (p_spill) else $error("spill not flagged"); // R4
    property p_status_clear;
        (ce && rx_status_access && ce && $onehot(full_reg) && !fill_evt && !blk_abort)
            |=> !rx_success_flag && !rx_irq;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("flag not cleared"); // R20
    property p_ignore_blk;
        (pop_ok && is_sof && f_blk && !rx_block_mode_bit && st_reg != F_BLK)
            |=> st_reg == F_IDLE;
    endproperty
    a_ignore_blk: assert property (p_ignore_blk) else $error("block frame not ignored"); // R10
endmodule : message_link_controller

// File: verification/bus_node_model.sv
// model of the far-side bus nodes: the decoded symbol stream and the raw receive pin
// assumes the bench calls its tasks from one process, right after a rising edge of mclk
`timescale 1ns/1ps
module bus_node_model
    import link_rx_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic sym_ready, // receiver has room
    output logic sym_valid, // symbol offered
    output logic [1:0] sym_kind, // symbol kind
    output logic sym_block, // block frame marker
    output logic [7:0] sym_byte, // data byte
    output logic rxp // raw bus activity, high active
);
    logic [7:0] byte_reg = 8'h00;
    logic [7:0] idle_reg = 8'h5a;
    initial begin
        sym_valid = 1'b0;
        sym_kind = K_DATA;
        sym_block = 1'b0;
        rxp = 1'b0;
    end
    // a released data line shows a pattern that changes every cycle
    assign sym_byte = sym_valid ? byte_reg : idle_reg;
    always @(posedge mclk) begin
        idle_reg <= idle_reg + 8'h35;
    end
    // one crc step, msb first
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : crc_step
    // offer one symbol and hold it until taken
    task automatic push(input logic [1:0] k, input logic b, input logic [7:0] d);
        sym_valid <= 1'b1;
        sym_kind <= k;
        sym_block <= b;
        byte_reg <= d;
        @(posedge mclk);
        while (sym_ready !== 1'b1) @(posedge mclk);
    endtask : push
    // whole frame: start, data, inverted crc, end; or an error symbol instead of the tail
    task automatic send_frame(input logic blk, input int n, input logic [7:0] base,
                              input logic err);
        logic [7:0] c;
        c = CRC_INIT;
        @(posedge mclk);
        rxp <= 1'b1;
        push(K_SOF, blk, 8'h00);
        for (int i = 0; i < n; i++) begin
            push(K_DATA, 1'b0, base + 8'(i));
            c = crc_step(c, base + 8'(i));
        end
        if (err) begin
            push(K_ERR, 1'b0, 8'h00);
        end else begin
            push(K_DATA, 1'b0, ~c);
            push(K_EOD, 1'b0, 8'h00);
        end
        sym_valid <= 1'b0;
        rxp <= 1'b0;
    endtask : send_frame
    // stray data symbols with no frame around them
    task automatic fill(input int n);
        @(posedge mclk);
        for (int i = 0; i < n; i++) push(K_DATA, 1'b0, 8'(i));
        sym_valid <= 1'b0;
    endtask : fill
    // passive to active transition on the bus
    task automatic bus_edge();
        @(posedge mclk);
        rxp <= 1'b1;
        repeat (4) @(posedge mclk);
        rxp <= 1'b0;
    endtask : bus_edge
endmodule : bus_node_model

// File: verification/tb_j1850_block_rx_and_low_power.sv
// self-checking bench of the block-mode receiver and its stop/wait control
// assumes the bus node model drives the symbol side; buffers shrunk to 4 bytes
`timescale 1ns/1ps
module tb_j1850_block_rx_and_low_power;
    import link_rx_pkg::*;
    localparam int DEP = 4;
    localparam int STAB = 16;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic cpu_stop = 1'b0, cpu_wait = 1'b0, blk_mode_set = 1'b0;
    logic wait_stop_select_bit = 1'b0;
    logic irq_enable_bit = 1'b1;
    logic rx_status_access = 1'b0;
    logic [1:0] rd_index = 2'h0;
    logic sense_wr = 1'b0, sense_val = 1'b0;
    logic sym_valid, sym_ready, sym_block, rxp;
    logic [1:0] sym_kind;
    logic [7:0] sym_byte, rd_data;
    logic [2:0] rx_count;
    logic rx_block_mode_bit, rx_success_flag, rx_overflow, rx_irq;
    logic wake_nmi, tx_sleep, power_sense_out;
    int failures = 0;
    int total_checks = 0;
    int nmi_seen = 0, ovf_seen = 0;
    int n0;
    // 50 MHz clock
    always #10 mclk = ~mclk;
    message_link_controller #(.DEPTH(DEP), .STAB_CYC(STAB)) DUT (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .sym_valid(sym_valid),
        .sym_ready(sym_ready), .sym_kind(sym_kind), .sym_block(sym_block),
        .sym_byte(sym_byte), .rxp(rxp), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
        .blk_mode_set(blk_mode_set), .wait_stop_select_bit(wait_stop_select_bit),
        .irq_enable_bit(irq_enable_bit), .rx_status_access(rx_status_access),
        .rd_index(rd_index), .sense_wr(sense_wr), .sense_val(sense_val),
        .rd_data(rd_data), .rx_count(rx_count), .rx_block_mode_bit(rx_block_mode_bit),
        .rx_success_flag(rx_success_flag), .rx_overflow(rx_overflow), .rx_irq(rx_irq),
        .wake_nmi(wake_nmi), .tx_sleep(tx_sleep), .power_sense_out(power_sense_out)
    );
    bus_node_model bus (
        .mclk(mclk), .sym_ready(sym_ready), .sym_valid(sym_valid), .sym_kind(sym_kind),
        .sym_block(sym_block), .sym_byte(sym_byte), .rxp(rxp)
    );
    // count the one-cycle pulses
    always @(posedge mclk) begin
        if (wake_nmi === 1'b1) nmi_seen++;
        if (rx_overflow === 1'b1) ovf_seen++;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    // one-cycle strobe: 0 stop, 1 wait, 2 arm block bit, 3 status access
    task automatic strobe(input int s);
        @(posedge mclk);
        case (s)
            0: cpu_stop <= 1'b1;
            1: cpu_wait <= 1'b1;
            2: blk_mode_set <= 1'b1;
            default: rx_status_access <= 1'b1;
        endcase
        @(posedge mclk);
        {cpu_stop, cpu_wait, blk_mode_set, rx_status_access} <= 4'h0;
    endtask : strobe
    task automatic sense(input logic v);
        @(posedge mclk);
        sense_wr <= 1'b1;
        sense_val <= v;
        @(posedge mclk);
        sense_wr <= 1'b0;
        #1 chk(8'(power_sense_out), 8'(v));
    endtask : sense
    task automatic rd_chk(input int idx, input logic [7:0] exp);
        @(posedge mclk);
        rd_index <= 2'(idx);
        @(posedge mclk);
        #1 chk(rd_data, exp);
    endtask : rd_chk
    task automatic wait_flag(input logic e);
        for (int i = 0; i < 100 && rx_success_flag !== e; i++) @(posedge mclk);
        #1 chk(8'(rx_success_flag), 8'(e));
    endtask : wait_flag
    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        settle(1);
        chk(8'(sym_ready), 8'h01);
        chk(8'(rx_success_flag), 8'h00);
        chk(8'(rx_block_mode_bit), 8'(BLK_BIT_RST));
        chk(8'(tx_sleep), 8'h00);
        chk(8'(power_sense_out), 8'(SENSE_RST));
        sense(1'b1);
        // normal frame: three bytes plus crc
        bus.send_frame(1'b0, 3, 8'h10, 1'b0);
        wait_flag(1'b1);
        chk(8'(rx_count), 8'h04);
        chk(8'(rx_irq), 8'h01);
        @(posedge mclk) irq_enable_bit <= 1'b0;
        settle(1);
        chk(8'(rx_irq), 8'h00);
        @(posedge mclk) irq_enable_bit <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(i, 8'h10 + 8'(i));
        strobe(3);
        settle(2);
        chk(8'(rx_success_flag), 8'h00);
        // block frame with the block bit clear is ignored, the next normal one taken
        bus.send_frame(1'b1, 3, 8'h20, 1'b0);
        settle(6);
        chk(8'(rx_success_flag), 8'h00);
        bus.send_frame(1'b0, 2, 8'h30, 1'b0);
        wait_flag(1'b1);
        rd_chk(1, 8'h31);
        strobe(3);
        // armed block frame spills from the first buffer into the second
        strobe(2);
        settle(1);
        chk(8'(rx_block_mode_bit), 8'h01);
        bus.send_frame(1'b1, 6, 8'h40, 1'b0);
        wait_flag(1'b1);
        settle(4);
        chk(8'(rx_block_mode_bit), 8'h00);
        chk(8'(rx_count), 8'(DEP));
        for (int i = 0; i < DEP; i++) rd_chk(i, 8'h40 + 8'(i));
        strobe(3);
        settle(2);
        chk(8'(rx_success_flag), 8'h01);
        chk(8'(rx_count), 8'h03);
        rd_chk(1, 8'h45);
        strobe(3);
        settle(2);
        chk(8'(rx_success_flag), 8'h00);
        // overflow when neither buffer is released
        strobe(2);
        bus.send_frame(1'b1, 10, 8'h60, 1'b0);
        settle(4);
        chk(8'(ovf_seen), 8'h01);
        chk(8'(rx_success_flag), 8'h00);
        chk(8'(rx_block_mode_bit), 8'h00);
        bus.send_frame(1'b0, 2, 8'h50, 1'b0);
        wait_flag(1'b1);
        chk(8'(rx_count), 8'h03);
        rd_chk(0, 8'h50);
        strobe(3);
        // error symbol after a buffer switch
        strobe(2);
        bus.send_frame(1'b1, 5, 8'h70, 1'b1);
        settle(4);
        chk(8'(rx_success_flag), 8'h00);
        chk(8'(rx_block_mode_bit), 8'h00);
        chk(8'(ovf_seen), 8'h01);
        // wait mode: frame received and wakes with interrupts enabled
        sense(1'b0);
        strobe(1);
        settle(1);
        chk(8'(tx_sleep), 8'h01);
        bus.send_frame(1'b0, 1, 8'h80, 1'b0);
        wait_flag(1'b1);
        settle(1);
        chk(8'(tx_sleep), 8'h00);
        rd_chk(0, 8'h80);
        strobe(3);
        sense(1'b1);
        // stop by the stop strobe, then by wait with the select bit
        for (int m = 0; m < 2; m++) begin
            sense(1'b0);
            @(posedge mclk);
            wait_stop_select_bit <= 1'(m);
            strobe(m);
            settle(1);
            chk(8'(tx_sleep), 8'h01);
            if (m == 0) begin
                bus.fill(FIFO_DEPTH);
                settle(1);
                chk(8'(sym_ready), 8'h00);
            end
            n0 = nmi_seen;
            bus.bus_edge();
            for (int i = 0; i < 10 && nmi_seen == n0; i++) @(posedge mclk);
            #1 chk(8'(nmi_seen - n0), 8'h01);
            chk(8'(tx_sleep), 8'h01);
            for (int i = 0; i < STAB + 20 && tx_sleep !== 1'b0; i++) @(posedge mclk);
            #1 chk(8'(tx_sleep), 8'h00);
            chk(8'(sym_ready), 8'h01);
            sense(1'b1);
        end
        complete_run();
    end
endmodule : tb_j1850_block_rx_and_low_power
